// file: design/acc_alu_core.sv
// Accumulator ALU datapath with two-stage fetch/execute pipeline.
// Assumes program memory and register-file memory on separate ports,
// both clocked by sys_clk, read data valid two cycles after the address.
`timescale 1ns/1ps
`default_nettype none
module acc_alu_core
	import acc_alu_pkg::*;
(
	input  wire logic               sys_clk,    // 40 MHz clock
	input  wire logic               rst,        // Synchronous reset
	output logic      [PC_W-1:0]    prog_addr,  // Program memory address
	input  wire logic [INSTR_W-1:0] prog_data,  // Fetched instruction word
	output logic      [ADDR_W-1:0]  data_addr,  // Register-file address
	input  wire logic [DATA_W-1:0]  data_rdata, // Register-file read data
	output logic      [DATA_W-1:0]  data_wdata, // Register-file write data
	output logic                    data_we     // Register-file write strobe
);
	phase_t              phase_ff;
	logic [PC_W-1:0]     pc_ff;
	logic [PC_W-1:0]     prog_addr_ff;
	logic [INSTR_W-1:0]  ir_ff;
	logic [DATA_W-1:0]   acc_ff;
	logic [DATA_W-1:0]   rd_ff;
	logic [ADDR_W-1:0]   ptr_ff;
	logic [ADDR_W-1:0]   data_addr_ff;
	logic [DATA_W-1:0]   data_wdata_ff;
	logic                data_we_ff;
	logic                c_ff;
	logic                nc_ff;
	logic                z_ff;
	logic [ADDR_W-1:0]   eff_addr;
	logic [DATA_W-1:0]   f_val;
	logic [DATA_W-1:0]   op_a;
	logic [DATA_W-1:0]   op_b;
	logic [DATA_W-1:0]   result;
	logic [8:0]          sum9;
	logic [4:0]          nib5;
	logic                is_arith;
	logic                is_sub;
	logic                upd_c;
	logic                upd_nc;
	logic                upd_z;
	logic                nxt_c;
	logic                dest_w;
	logic                dest_f;
	logic                branch;
	logic [PC_W-1:0]     target;
	logic                exec;
	assign exec = (phase_ff == PH_FOUR);
	// Phase sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase_ff <= PH_ONE;
		end else begin
			case (phase_ff)
				PH_ONE:   phase_ff <= PH_TWO;
				PH_TWO:   phase_ff <= PH_THREE;
				PH_THREE: phase_ff <= PH_FOUR;
				PH_FOUR:  phase_ff <= PH_ONE;
				default:  phase_ff <= PH_ONE;
			endcase
		end
	end
	// Indirect slot goes through the pointer register
	assign eff_addr = (ir_ff[6:0] == ADR_INDIRECT) ? ptr_ff : ir_ff[6:0];
	// Program counter and fetch
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pc_ff        <= PC_RESET;
			prog_addr_ff <= PC_RESET;
		end else if (phase_ff == PH_ONE) begin
			prog_addr_ff <= pc_ff;
			pc_ff        <= pc_ff + 11'h001;
		end else if (exec && branch) begin
			pc_ff <= target;
		end
	end
	// Instruction register; prefetch overlaps execution
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ir_ff <= NOP_WORD;
		end else if (exec) begin
			ir_ff <= branch ? NOP_WORD : prog_data;
		end
	end
	// Operand read, special registers served from inside
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			data_addr_ff <= 7'h00;
			rd_ff        <= BYTE_ZERO;
		end else if (phase_ff == PH_ONE) begin
			data_addr_ff <= eff_addr;
		end else if (phase_ff == PH_THREE) begin
			case (data_addr_ff)
				ADR_PC_LOW:  rd_ff <= pc_ff[7:0];
				ADR_FLAGS:   rd_ff <= {5'h00, z_ff, nc_ff, c_ff};
				ADR_POINTER: rd_ff <= {1'b0, ptr_ff};
				default:     rd_ff <= data_rdata;
			endcase
		end
	end
	assign f_val = rd_ff;
	// Decode and ALU
	always_comb begin
		op_a     = f_val;
		op_b     = acc_ff;
		result   = BYTE_ZERO;
		is_arith = 1'b0;
		is_sub   = 1'b0;
		upd_c    = 1'b0;
		upd_nc   = 1'b0;
		upd_z    = 1'b0;
		nxt_c    = c_ff;
		dest_w   = 1'b0;
		dest_f   = 1'b0;
		branch   = 1'b0;
		target   = ir_ff[10:0];
		case (ir_ff[13:12])
			CLS_BYTE: begin
				dest_w = ~ir_ff[7];
				dest_f = ir_ff[7];
				upd_z  = 1'b1;
				case (ir_ff[11:8])
					OP_STORE: begin
						result = acc_ff;
						dest_w = 1'b0;
						upd_z  = 1'b0;
					end
					OP_CLR:  result = BYTE_ZERO;
					OP_SUB: begin
						is_arith = 1'b1;
						is_sub   = 1'b1;
					end
					OP_DEC:  result = f_val - 8'h01;
					OP_IOR:  result = f_val | acc_ff;
					OP_AND:  result = f_val & acc_ff;
					OP_XOR:  result = f_val ^ acc_ff;
					OP_ADD:  is_arith = 1'b1;
					OP_MOV:  result = f_val;
					OP_COM:  result = ~f_val;
					OP_INC:  result = f_val + 8'h01;
					OP_RRC: begin
						result = {c_ff, f_val[7:1]};
						nxt_c  = f_val[0];
						upd_c  = 1'b1;
						upd_z  = 1'b0;
					end
					OP_RLC: begin
						result = {f_val[6:0], c_ff};
						nxt_c  = f_val[7];
						upd_c  = 1'b1;
						upd_z  = 1'b0;
					end
					OP_SWAP: begin
						result = {f_val[3:0], f_val[7:4]};
						upd_z  = 1'b0;
					end
					default: begin
						dest_w = 1'b0;
						dest_f = 1'b0;
						upd_z  = 1'b0;
					end
				endcase
			end
			CLS_LIT: begin
				op_a   = ir_ff[7:0];
				dest_w = 1'b1;
				upd_z  = 1'b1;
				if (ir_ff[11:10] == 2'h0) begin
					result = ir_ff[7:0];
					upd_z  = 1'b0;
				end else if (ir_ff[11:10] == 2'h3) begin
					is_arith = 1'b1;
					is_sub   = ~ir_ff[9];
				end else begin
					case (ir_ff[11:8])
						LOP_IOR: result = ir_ff[7:0] | acc_ff;
						LOP_AND: result = ir_ff[7:0] & acc_ff;
						LOP_XOR: result = ir_ff[7:0] ^ acc_ff;
						default: begin
							dest_w = 1'b0;
							upd_z  = 1'b0;
						end
					endcase
				end
			end
			CLS_JUMP: branch = ir_ff[11];
			default: ;
		endcase
		// Subtract as a + ~b + 1 so carries read as no-borrow
		sum9 = {1'b0, op_a} + {1'b0, (is_sub ? ~op_b : op_b)} + {8'h00, is_sub};
		nib5 = {1'b0, op_a[3:0]} + {1'b0, (is_sub ? ~op_b[3:0] : op_b[3:0])}
			+ {4'h0, is_sub};
		if (is_arith) begin
			result = sum9[7:0];
			nxt_c  = sum9[8];
			upd_c  = 1'b1;
			upd_nc = 1'b1;
		end
	end
	// Accumulator, pointer and flags
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_ff <= BYTE_ZERO;
			ptr_ff <= 7'h00;
			c_ff   <= 1'b0;
			nc_ff  <= 1'b0;
			z_ff   <= 1'b0;
		end else if (exec) begin
			if (dest_w) begin
				acc_ff <= result;
			end
			if (dest_f && eff_addr == ADR_POINTER) begin
				ptr_ff <= result[6:0];
			end
			if (dest_f && eff_addr == ADR_FLAGS) begin
				c_ff  <= result[FLG_CARRY];
				nc_ff <= result[FLG_NIBBLE];
				z_ff  <= result[FLG_ZERO];
			end
			// Flag updates win over a direct write
			if (upd_c) begin
				c_ff <= nxt_c;
			end
			if (upd_nc) begin
				nc_ff <= nib5[4];
			end
			if (upd_z) begin
				z_ff <= (result == BYTE_ZERO);
			end
		end
	end
	// Writes to ordinary file locations go out on the data bus
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			data_we_ff    <= 1'b0;
			data_wdata_ff <= BYTE_ZERO;
		end else begin
			data_we_ff <= exec && dest_f && eff_addr != ADR_PC_LOW
				&& eff_addr != ADR_FLAGS && eff_addr != ADR_POINTER;
			if (exec && dest_f) begin
				data_wdata_ff <= result;
			end
		end
	end
	assign prog_addr  = prog_addr_ff;
	assign data_addr  = data_addr_ff;
	assign data_wdata = data_wdata_ff;
	assign data_we    = data_we_ff;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	phase_order_a: assert property (
		(phase_ff == PH_ONE) |=> (phase_ff == PH_TWO) ##1 (phase_ff == PH_THREE)
			##1 (phase_ff == PH_FOUR))
		else $error("phase order broken");
	pc_step_a: assert property (
		(phase_ff == PH_ONE) |=> pc_ff == $past(pc_ff) + 11'h001)
		else $error("pc did not step in phase one");
	fetch_addr_a: assert property (
		(phase_ff == PH_ONE) |=> prog_addr == $past(pc_ff))
		else $error("fetch address wrong");
	write_once_a: assert property (
		data_we |=> !data_we [*3])
		else $error("more than one write per instruction cycle");
	flush_nop_a: assert property (
		(exec && branch) |=> ir_ff == NOP_WORD ##4 prog_addr == $past(target, 5))
		else $error("branch did not flush and refetch");
	ir_latch_a: assert property (
		(exec && !branch) |=> ir_ff == $past(prog_data))
		else $error("instruction not latched");
	zero_flag_a: assert property (
		(exec && upd_z && !(dest_f && eff_addr == ADR_FLAGS)) |=> z_ff == ($past(result) == BYTE_ZERO))
		else $error("zero flag wrong");
	acc_load_a: assert property (
		(exec && dest_w) |=> acc_ff == $past(result))
		else $error("accumulator not loaded");
	borrow_a: assert property (
		(exec && is_sub && is_arith) |=> c_ff == ($past(op_a) >= $past(op_b)))
		else $error("borrow flag wrong");
	branch_c: cover property (exec && branch);
	sub_borrow_c: cover property (exec && is_sub && is_arith && (op_a < op_b));
	file_write_c: cover property (data_we);
endmodule // acc_alu_core
`default_nettype wire

// file: design/acc_alu_pkg.sv
// Constants for the accumulator ALU datapath: widths, phases, opcodes,
// special register addresses and flag positions.
// Assumes one 40 MHz clock and synchronous active-high reset.
package acc_alu_pkg;
	localparam int INSTR_W = 14;
	localparam int PC_W    = 11;
	localparam int DATA_W  = 8;
	localparam int ADDR_W  = 7;

	// Instruction cycle of four phases, Gray order
	typedef enum logic [1:0] {
		PH_ONE   = 2'h0,
		PH_TWO   = 2'h1,
		PH_THREE = 2'h3,
		PH_FOUR  = 2'h2
	} phase_t;

	// Instruction classes, bits 13:12
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_JUMP = 2'h2;
	localparam logic [1:0] CLS_LIT  = 2'h3;

	// Byte-oriented operations, bits 11:8
	localparam logic [3:0] OP_STORE = 4'h0;
	localparam logic [3:0] OP_CLR   = 4'h1;
	localparam logic [3:0] OP_SUB   = 4'h2;
	localparam logic [3:0] OP_DEC   = 4'h3;
	localparam logic [3:0] OP_IOR   = 4'h4;
	localparam logic [3:0] OP_AND   = 4'h5;
	localparam logic [3:0] OP_XOR   = 4'h6;
	localparam logic [3:0] OP_ADD   = 4'h7;
	localparam logic [3:0] OP_MOV   = 4'h8;
	localparam logic [3:0] OP_COM   = 4'h9;
	localparam logic [3:0] OP_INC   = 4'hA;
	localparam logic [3:0] OP_RRC   = 4'hC;
	localparam logic [3:0] OP_RLC   = 4'hD;
	localparam logic [3:0] OP_SWAP  = 4'hE;

	// Literal operations, bits 11:8 (upper bits decide)
	localparam logic [3:0] LOP_IOR = 4'h8;
	localparam logic [3:0] LOP_AND = 4'h9;
	localparam logic [3:0] LOP_XOR = 4'hA;

	localparam logic [13:0] NOP_WORD = 14'h0000;

	// Register-file addresses of the mapped special registers
	localparam logic [6:0] ADR_INDIRECT = 7'h00;
	localparam logic [6:0] ADR_PC_LOW   = 7'h02;
	localparam logic [6:0] ADR_FLAGS    = 7'h03;
	localparam logic [6:0] ADR_POINTER  = 7'h04;

	// Flag bit positions in the flags register
	localparam int FLG_CARRY  = 0;
	localparam int FLG_NIBBLE = 1;
	localparam int FLG_ZERO   = 2;

	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
endpackage

// file: testbench/prog_data_mem.sv
// Program memory and register-file memory facing the datapath.
// Assumes the bench fills rom and ram while reset is held.
`timescale 1ns/1ps
`default_nettype none
module prog_data_mem
	import acc_alu_pkg::*;
(
	input  wire logic               sys_clk,    // Clock
	input  wire logic [PC_W-1:0]    prog_addr,  // Fetch address
	output logic      [INSTR_W-1:0] prog_data,  // Instruction word
	input  wire logic [ADDR_W-1:0]  data_addr,  // File address
	output logic      [DATA_W-1:0]  data_rdata, // File read data
	input  wire logic [DATA_W-1:0]  data_wdata, // File write data
	input  wire logic               data_we     // File write strobe
);
	logic [INSTR_W-1:0] rom [2**PC_W];
	logic [DATA_W-1:0]  ram [2**ADDR_W];

	// Two independent ports, both read without delay
	assign prog_data  = rom[prog_addr];
	assign data_rdata = ram[data_addr];

	always @(posedge sys_clk) begin
		if (data_we) begin
			ram[data_addr] <= data_wdata;
		end
	end
endmodule // prog_data_mem
`default_nettype wire

// file: testbench/tb_acc_alu_core.sv
// Self-checking bench: small programs run from the memory model,
// results read back from its file memory. Assumes the memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_acc_alu_core;
	import acc_alu_pkg::*;
	logic               sys_clk;
	logic               rst;
	logic [PC_W-1:0]    prog_addr;
	logic [INSTR_W-1:0] prog_data;
	logic [ADDR_W-1:0]  data_addr;
	logic [DATA_W-1:0]  data_rdata;
	logic [DATA_W-1:0]  data_wdata;
	logic               data_we;
	logic [PC_W-1:0]    last_pc = '0;
	int                 mismatches = 0;
	int                 tests_run = 0;
	int                 cycles = 0;
	int                 gap = 0;

	acc_alu_core acc_alu_core_i (.sys_clk(sys_clk), .rst(rst), .prog_addr(prog_addr),
		.prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
		.data_wdata(data_wdata), .data_we(data_we));
	prog_data_mem prog_data_mem_i (.sys_clk(sys_clk), .prog_addr(prog_addr),
		.prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
		.data_wdata(data_wdata), .data_we(data_we));

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic logic [13:0] bop(logic [3:0] op, logic d, logic [6:0] f);
		return {CLS_BYTE, op, d, f};
	endfunction

	// Load a program under reset, then run n + 2 instruction cycles
	task automatic run(input logic [13:0] w [$], input int n);
		@(negedge sys_clk);
		rst = 1'b1;
		for (int i = 0; i < 2**PC_W; i++) begin
			prog_data_mem_i.rom[i] = (i < w.size()) ? w[i] : NOP_WORD;
		end
		for (int i = 0; i < 2**ADDR_W; i++) begin
			prog_data_mem_i.ram[i] = 8'hEE;
		end
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4 * n + 8) @(negedge sys_clk);
	endtask

	task automatic t_add_wrap();
		run('{14'h30FF, 14'h3E01, bop(OP_STORE, 1'b1, 7'h24),
			bop(OP_MOV, 1'b0, ADR_FLAGS), bop(OP_STORE, 1'b1, 7'h25)}, 5);
		chk8(prog_data_mem_i.ram[7'h24], 8'h00);
		chk8(prog_data_mem_i.ram[7'h25], 8'h07);
	endtask

	task automatic t_sub_borrow();
		run('{14'h3010, bop(OP_STORE, 1'b1, 7'h22), 14'h3020, bop(OP_SUB, 1'b1, 7'h22),
			bop(OP_MOV, 1'b0, ADR_FLAGS), bop(OP_STORE, 1'b1, 7'h23)}, 6);
		chk8(prog_data_mem_i.ram[7'h22], 8'hF0);
		chk8(prog_data_mem_i.ram[7'h23], 8'h02);
	endtask

	task automatic t_rotate_logic();
		run('{14'h3081, bop(OP_STORE, 1'b1, 7'h26), bop(OP_RLC, 1'b1, 7'h26),
			bop(OP_MOV, 1'b0, ADR_FLAGS), bop(OP_STORE, 1'b1, 7'h27), 14'h300F,
			14'h3AFF, bop(OP_STORE, 1'b1, 7'h28)}, 8);
		chk8(prog_data_mem_i.ram[7'h26], 8'h02);
		chk8(prog_data_mem_i.ram[7'h27], 8'h01);
		chk8(prog_data_mem_i.ram[7'h28], 8'hF0);
	endtask

	task automatic t_indirect();
		run('{14'h3030, bop(OP_STORE, 1'b1, ADR_POINTER), 14'h3099,
			bop(OP_STORE, 1'b1, ADR_INDIRECT)}, 4);
		chk8(prog_data_mem_i.ram[7'h30], 8'h99);
		chk8(prog_data_mem_i.ram[7'h04], 8'hEE);
	endtask

	task automatic t_jump();
		run('{14'h2805, bop(OP_STORE, 1'b1, 7'h21), NOP_WORD, NOP_WORD, NOP_WORD,
			14'h305A, bop(OP_STORE, 1'b1, 7'h20)}, 9);
		chk8(prog_data_mem_i.ram[7'h21], 8'hEE);
		chk8(prog_data_mem_i.ram[7'h20], 8'h5A);
	endtask

	// Byte-oriented logic, complement and step on one location, then a clear on another
	task automatic t_logic_chain();
		run('{14'h30C3, bop(OP_STORE, 1'b1, 7'h40), 14'h3035,
			bop(OP_AND, 1'b1, 7'h40), bop(OP_IOR, 1'b1, 7'h40),
			bop(OP_XOR, 1'b1, 7'h40), bop(OP_MOV, 1'b0, ADR_FLAGS),
			bop(OP_STORE, 1'b1, 7'h41), bop(OP_COM, 1'b1, 7'h40),
			bop(OP_INC, 1'b1, 7'h40), bop(OP_DEC, 1'b0, 7'h40),
			bop(OP_STORE, 1'b1, 7'h42), bop(OP_CLR, 1'b1, 7'h43)}, 13);
		chk8(prog_data_mem_i.ram[7'h40], 8'h00);
		chk8(prog_data_mem_i.ram[7'h41], 8'h04);
		chk8(prog_data_mem_i.ram[7'h42], 8'hFF);
		chk8(prog_data_mem_i.ram[7'h43], 8'h00);
	endtask

	// Swap, literal logic, add, literal subtract, rotate right, pc and indirect reads
	task automatic t_arith_special();
		run('{14'h3096, bop(OP_STORE, 1'b1, 7'h50), bop(OP_SWAP, 1'b1, 7'h50),
			14'h3988, 14'h3801, bop(OP_ADD, 1'b1, 7'h50), 14'h3CF1,
			bop(OP_RRC, 1'b1, 7'h50), bop(OP_MOV, 1'b0, ADR_FLAGS),
			bop(OP_STORE, 1'b1, 7'h51), bop(OP_MOV, 1'b0, ADR_PC_LOW),
			bop(OP_STORE, 1'b1, 7'h52), 14'h3050, bop(OP_STORE, 1'b1, ADR_POINTER),
			bop(OP_MOV, 1'b0, ADR_INDIRECT), bop(OP_STORE, 1'b1, 7'h53)}, 16);
		chk8(prog_data_mem_i.ram[7'h50], 8'hF5);
		chk8(prog_data_mem_i.ram[7'h51], 8'h02);
		chk8(prog_data_mem_i.ram[7'h52], 8'h0C);
		chk8(prog_data_mem_i.ram[7'h53], 8'hF5);
	endtask

	// Fetch address must step once every four clocks
	always @(posedge sys_clk) begin
		if (rst) begin
			gap <= 0;
		end else if (prog_addr !== last_pc) begin
			if (gap != 0) begin
				chk8(8'(gap), 8'h04);
			end
			gap <= 1;
		end else if (gap != 0) begin
			gap <= gap + 1;
		end
		last_pc <= prog_addr;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever begin
			#12.5 sys_clk = ~sys_clk;
		end
	end

	initial begin
		rst = 1'b1;
		t_add_wrap();
		t_sub_borrow();
		t_rotate_logic();
		t_indirect();
		t_jump();
		t_logic_chain();
		t_arith_special();
		tally_and_finish();
	end
endmodule // tb_acc_alu_core
`default_nettype wire
